// [rtl/adcrr_map.svh]
`ifndef ADCRR_MAP_SVH
`define ADCRR_MAP_SVH
// Channel identifiers
`define ADCRR_ID_A 8'h3A
`define ADCRR_ID_B 8'h3B
`define ADCRR_ID_C 8'h3C
`define ADCRR_ID_D 8'h3D
// Read and write command words
`define ADCRR_RD_A 16'h3A00
`define ADCRR_RD_B 16'h3B00
`define ADCRR_RD_C 16'h3C00
`define ADCRR_RD_D 16'h3D00
`define ADCRR_WR_A 16'h0074
`define ADCRR_WR_B 16'h0076
`define ADCRR_WR_C 16'h0078
`define ADCRR_WR_D 16'h007A
// Frame layout
`define ADCRR_FRAME_BITS 6'h20
`define ADCRR_CMD_MSB 31
`define ADCRR_CMD_LSB 16
`define ADCRR_REQ_MSB 6
`define ADCRR_REQ_LSB 0
// Reset values
`define ADCRR_REQ_RST 7'h00
`define ADCRR_RES_RST 10'h000
// Code ranges
`define ADCRR_CODE_LO1 7'h01
`define ADCRR_CODE_HI1 7'h13
`define ADCRR_ESR_BASE 7'h14
`define ADCRR_CODE_LO2 7'h20
`define ADCRR_CODE_HI2 7'h41
`define ADCRR_CODE_LO3 7'h46
`define ADCRR_CODE_HI3 7'h51
// Serial clock: half period time and cycles at 40 MHz
`define ADCRR_CLK_MHZ 40
`define ADCRR_SCK_HALF_NS 400
`define ADCRR_SCK_HALF (`ADCRR_SCK_HALF_NS * `ADCRR_CLK_MHZ / 1000)
`endif

// [rtl/adcrr_pkg.sv]
`include "adcrr_map.svh"
package adcrr_pkg;
  typedef enum logic [1:0] {
    CV_IDLE = 2'b00,
    CV_BUSY = 2'b01
  } adcrr_cstate_e;

  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_SHIFT = 2'b01,
    HS_TRAIL = 2'b10,
    HS_GAP = 2'b11
  } adcrr_hstate_e;

  function automatic logic [15:0] rdCmd(input logic [1:0] ch);
    unique case (ch)
      2'h0: rdCmd = `ADCRR_RD_A;
      2'h1: rdCmd = `ADCRR_RD_B;
      2'h2: rdCmd = `ADCRR_RD_C;
      2'h3: rdCmd = `ADCRR_RD_D;
    endcase
  endfunction : rdCmd

  function automatic logic [15:0] wrCmd(input logic [1:0] ch);
    unique case (ch)
      2'h0: wrCmd = `ADCRR_WR_A;
      2'h1: wrCmd = `ADCRR_WR_B;
      2'h2: wrCmd = `ADCRR_WR_C;
      2'h3: wrCmd = `ADCRR_WR_D;
    endcase
  endfunction : wrCmd

  function automatic logic [7:0] chanId(input logic [1:0] ch);
    unique case (ch)
      2'h0: chanId = `ADCRR_ID_A;
      2'h1: chanId = `ADCRR_ID_B;
      2'h2: chanId = `ADCRR_ID_C;
      2'h3: chanId = `ADCRR_ID_D;
    endcase
  endfunction : chanId
endpackage : adcrr_pkg

// [rtl/adcrr_if.sv]
`timescale 1ns/100ps
`default_nettype none
interface adcrr_if;
  logic sck;
  logic csN;
  logic mosi;
  logic miso;
  logic misoOe;
  modport host (output sck, output csN, output mosi, input miso);
  modport dev (input sck, input csN, input mosi, output miso,
    output misoOe);
endinterface : adcrr_if
`default_nettype wire

// [rtl/adcrr_device.sv]
`timescale 1ns/100ps
`default_nettype none
`include "adcrr_map.svh"
// Function
// RQ1: Channel B id 3B, cmds 3B00/0076.
// RQ2: Channel C id 3C, cmds 3C00/0078.
// RQ3: Channel D id 3D, cmds 3D00/007A.
// RQ4: Channel A id 3A, cmds 3A00/0074.
// RQ5: New-data flag set on done, cleared.
// RQ6: Seven-bit select code, write or reset.
// RQ7: Codes 01..13 select references and sensors.
// RQ8: ESR codes only echoed, never accepted.
// RQ9: Codes 20..2B select supply pin voltages.
// RQ10: Codes 2C..41, 46..51 select output pins.
// RQ11: Ten-bit result, cleared by soft reset.
// RQ12: Ignore upper payload, zeros, unused codes.
// RQ13: Controller polls, takes flag with result.
module adcrr_device (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Serial link
  adcrr_if.dev link,
  // Soft state-machine reset
  input wire logic softReset,
  // Converter state machine
  output logic convReq,
  output logic [1:0] convChan,
  output logic [6:0] convCode,
  input wire logic convDone,
  input wire logic [9:0] convResult,
  // ESR measurement results
  input wire logic esrLoad,
  input wire logic [1:0] esrChan,
  input wire logic [1:0] esrSel,
  input wire logic [9:0] esrResult
);
  typedef struct packed {
    logic [2:0] sckS;
    logic [2:0] csS;
    logic [2:0] mosiS;
    logic sckF;
    logic csF;
    logic mosiF;
    logic [5:0] bits;
    logic [31:0] rx;
    logic [31:0] tx;
    logic misoOe;
    logic [3:0] flag;
    logic [3:0][6:0] code;
    logic [3:0][6:0] echo;
    logic [3:0][9:0] res;
    logic [3:0] pend;
    adcrr_pkg::adcrr_cstate_e st;
    logic convReq;
    logic [1:0] convChan;
    logic [6:0] convCode;
  } adcrr_dev_s;

  adcrr_dev_s s;
  adcrr_dev_s next_s;

  // Accepted request codes
  function automatic logic codeOk(input logic [6:0] c);
    codeOk = (c >= `ADCRR_CODE_LO1 && c <= `ADCRR_CODE_HI1) ||
      (c >= `ADCRR_CODE_LO2 && c <= `ADCRR_CODE_HI2) ||
      (c >= `ADCRR_CODE_LO3 && c <= `ADCRR_CODE_HI3);
  endfunction : codeOk

  // Payload bits above the code are dropped
  function automatic logic [6:0] payCode(input logic [31:0] w);
    payCode = w[`ADCRR_REQ_MSB:`ADCRR_REQ_LSB];
  endfunction : payCode

  // Reserved reply bits read as zero
  function automatic logic [31:0] replyWord(input logic [7:0] id,
    input logic f, input logic [6:0] e, input logic [9:0] r);
    replyWord = {4'h0, id, f, 2'b00, e, r};
  endfunction : replyWord

  logic fSck;
  logic fCs;
  logic fMosi;
  logic [3:0] setFlag;
  logic [3:0] clrFlag;
  logic [1:0] pick;
  logic [15:0] cmd;

  always_comb begin
    next_s = s;
    setFlag = 4'h0;
    clrFlag = 4'h0;
    pick = 2'h0;
    cmd = s.rx[`ADCRR_CMD_MSB:`ADCRR_CMD_LSB];
    next_s.sckS = {s.sckS[1:0], link.sck};
    next_s.csS = {s.csS[1:0], link.csN};
    next_s.mosiS = {s.mosiS[1:0], link.mosi};
    // Glitch filter: second and third stage must agree
    fSck = (s.sckS[1] == s.sckS[2]) ? s.sckS[2] : s.sckF;
    fCs = (s.csS[1] == s.csS[2]) ? s.csS[2] : s.csF;
    fMosi = (s.mosiS[1] == s.mosiS[2]) ? s.mosiS[2] : s.mosiF;
    next_s.sckF = fSck;
    next_s.csF = fCs;
    next_s.mosiF = fMosi;
    next_s.misoOe = ~fCs;
    next_s.convReq = 1'b0;
    if (!fCs && s.csF) begin
      next_s.bits = 6'h00;
    end
    if (!fCs && fSck && !s.sckF) begin
      next_s.rx = {s.rx[30:0], fMosi};
      next_s.bits = s.bits + 6'h01;
    end
    // Reply bits move on the falling edge
    if (!fCs && !fSck && s.sckF) begin
      next_s.tx = {s.tx[30:0], 1'b0};
    end
    // Frame completes on chip-select release
    if (fCs && !s.csF) begin
      next_s.tx = 32'h0000_0000;
      if (s.bits == `ADCRR_FRAME_BITS) begin
        for (int i = 0; i < 4; i++) begin
          // RQ4 RQ1 RQ2 RQ3 read decode
          if (cmd == adcrr_pkg::rdCmd(2'(i))) begin
            // RQ12 reserved bits zero
            next_s.tx = replyWord(adcrr_pkg::chanId(2'(i)), s.flag[i],
              s.echo[i], s.res[i]);
            // RQ5 clear on read
            clrFlag[i] = 1'b1;
          end
          // RQ4 RQ1 RQ2 RQ3 write decode
          if (cmd == adcrr_pkg::wrCmd(2'(i))) begin
            // RQ6 RQ12 only low seven bits kept
            next_s.code[i] = payCode(s.rx);
            next_s.echo[i] = payCode(s.rx);
            // RQ7 RQ8 RQ9 RQ10 RQ12 accepted codes convert
            next_s.pend[i] = codeOk(payCode(s.rx));
          end
        end
      end
    end
    // RQ8 ESR codes reach only the echo field
    if (esrLoad && esrSel != 2'h3) begin
      next_s.echo[esrChan] = `ADCRR_ESR_BASE + {5'h00, esrSel};
      next_s.res[esrChan] = esrResult;
      setFlag[esrChan] = 1'b1;
    end
    for (int i = 3; i >= 0; i--) begin
      if (s.pend[i]) begin
        pick = 2'(i);
      end
    end

    unique case (s.st)
      adcrr_pkg::CV_IDLE: begin
        if (|s.pend) begin
          next_s.convReq = 1'b1;
          next_s.convChan = pick;
          next_s.convCode = s.code[pick];
          next_s.pend[pick] = 1'b0;
          next_s.st = adcrr_pkg::CV_BUSY;
        end
      end
      adcrr_pkg::CV_BUSY: begin
        if (convDone) begin
          // RQ11 result store
          next_s.res[s.convChan] = convResult;
          next_s.echo[s.convChan] = s.convCode;
          // RQ5 set when done
          setFlag[s.convChan] = 1'b1;
          next_s.st = adcrr_pkg::CV_IDLE;
        end
      end
    endcase
    // Set beats clear in the same cycle
    next_s.flag = (s.flag & ~clrFlag) | setFlag;

    // RQ5 RQ6 RQ11 soft reset clears channel state
    if (softReset) begin
      next_s.flag = 4'h0;
      next_s.code = '0;
      next_s.echo = '0;
      next_s.res = '0;
      next_s.pend = 4'h0;
      next_s.convReq = 1'b0;
      next_s.st = adcrr_pkg::CV_IDLE;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.sckS <= 3'h0;
      s.csS <= 3'h7;
      s.csF <= 1'b1;
      s.st <= adcrr_pkg::CV_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign link.miso = s.tx[31];
  assign link.misoOe = s.misoOe;
  assign convReq = s.convReq;
  assign convChan = s.convChan;
  assign convCode = s.convCode;
endmodule : adcrr_device
`default_nettype wire

// [rtl/adcrr_host.sv]
`timescale 1ns/100ps
`default_nettype none
`include "adcrr_map.svh"
module adcrr_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Serial link
  adcrr_if.host link,
  // Request
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [1:0] reqChan,
  input wire logic [6:0] reqCode,
  output logic reqReady,
  // Response
  output logic rspValid,
  output logic [31:0] rspData
);
  localparam logic [7:0] HALF = 8'(`ADCRR_SCK_HALF);

  typedef struct packed {
    adcrr_pkg::adcrr_hstate_e st;
    logic [7:0] cnt;
    logic [5:0] bits;
    logic [31:0] tx;
    logic [31:0] rx;
    logic [2:0] misoS;
    logic misoF;
    logic sck;
    logic csN;
    logic mosi;
    logic ready;
    logic rspValid;
    logic [31:0] rspData;
  } adcrr_host_s;

  adcrr_host_s s;
  adcrr_host_s next_s;
  logic halfDone;

  always_comb begin
    next_s = s;
    next_s.misoS = {s.misoS[1:0], link.miso};
    if (s.misoS[1] == s.misoS[2]) begin
      next_s.misoF = s.misoS[2];
    end
    next_s.rspValid = 1'b0;
    halfDone = (s.cnt == HALF - 8'h01);
    next_s.cnt = halfDone ? 8'h00 : s.cnt + 8'h01;
    unique case (s.st)
      adcrr_pkg::HS_IDLE: begin
        next_s.cnt = 8'h00;
        if (reqValid) begin
          // RQ4 RQ1 RQ2 RQ3 command words
          next_s.tx = reqWrite ?
            {adcrr_pkg::wrCmd(reqChan), 9'h000, reqCode} :
            {adcrr_pkg::rdCmd(reqChan), 16'h0000};
          next_s.mosi = reqWrite ? 1'b0 : adcrr_pkg::rdCmd(reqChan)[15];
          next_s.csN = 1'b0;
          next_s.bits = 6'h00;
          next_s.ready = 1'b0;
          next_s.st = adcrr_pkg::HS_SHIFT;
        end
      end
      adcrr_pkg::HS_SHIFT: begin
        if (halfDone) begin
          if (!s.sck) begin
            next_s.sck = 1'b1;
            next_s.rx = {s.rx[30:0], s.misoF};
          end else begin
            next_s.sck = 1'b0;
            next_s.tx = {s.tx[30:0], 1'b0};
            next_s.mosi = s.tx[30];
            next_s.bits = s.bits + 6'h01;
            if (s.bits == `ADCRR_FRAME_BITS - 6'h01) begin
              next_s.st = adcrr_pkg::HS_TRAIL;
            end
          end
        end
      end
      adcrr_pkg::HS_TRAIL: begin
        if (halfDone) begin
          next_s.csN = 1'b1;
          next_s.mosi = 1'b0;
          // RQ13 flag and result leave in one word
          next_s.rspValid = 1'b1;
          next_s.rspData = s.rx;
          next_s.st = adcrr_pkg::HS_GAP;
        end
      end
      adcrr_pkg::HS_GAP: begin
        if (halfDone) begin
          next_s.ready = 1'b1;
          next_s.st = adcrr_pkg::HS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.st <= adcrr_pkg::HS_IDLE;
      s.csN <= 1'b1;
      s.ready <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign link.sck = s.sck;
  assign link.csN = s.csN;
  assign link.mosi = s.mosi;
  assign reqReady = s.ready;
  assign rspValid = s.rspValid;
  assign rspData = s.rspData;
endmodule : adcrr_host
`default_nettype wire

// [test/adcrr_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module adcrr_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Serial link
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  input wire logic miso,
  input wire logic misoOe
);
  logic sckQ;
  logic [5:0] bits;
  logic [5:0] hiCnt;
  logic [31:0] mSh;
  logic [31:0] sSh;
  logic [7:0] pId;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // Reply id comes from the frame before
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sckQ <= 1'b0;
      bits <= 6'h00;
      hiCnt <= 6'h00;
      mSh <= 32'h0;
      sSh <= 32'h0;
      pId <= 8'h00;
    end else begin
      sckQ <= sck;
      hiCnt <= sck ? hiCnt + 6'h01 : 6'h00;
      if (csN) begin
        bits <= 6'h00;
      end else if (sck && !sckQ) begin
        bits <= bits + 6'h01;
        mSh <= {mSh[30:0], mosi};
        sSh <= {sSh[30:0], miso};
      end
      if (csN && bits == 6'h20) begin
        pId <= mSh[31:24];
      end
    end
  end
  a_idle_sck_low: assert property (csN |-> !sck)
    else $error("serial clock moves outside frame");
  a_bit_count: assert property ($rose(csN) |-> bits == 6'h20)
    else $error("frame length is not 32 bits");
  a_cmd_word: assert property ($rose(csN) |-> mSh[31:16] inside
    {16'h3A00, 16'h3B00, 16'h3C00, 16'h3D00,
     16'h0074, 16'h0076, 16'h0078, 16'h007A})
    else $error("unknown command word");
  a_pad_zero: assert property ($rose(csN) |-> mSh[15:7] == 9'h000)
    else $error("payload padding not zero");
  a_mosi_hold: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("host data moved while clock high");
  a_half_high: assert property ($fell(sck) |-> hiCnt == 6'h10)
    else $error("clock high time wrong");
  a_reply_head: assert property ($rose(csN) |->
    sSh[31:28] == 4'h0 && sSh[18:17] == 2'h0)
    else $error("reply reserved bits not zero");
  a_reply_id: assert property ($rose(csN) |-> sSh[27:20] == pId)
    else $error("reply id does not match read");
  a_oe_follows: assert property ($fell(csN) |-> ##[1:8] misoOe)
    else $error("device did not drive its data line");
  a_gap_min: assert property ($rose(csN) |=> csN [*8])
    else $error("frame gap too short");
  cover property ($rose(csN) && mSh[23:16] == 8'h00);
  cover property ($rose(csN) && mSh[31:24] == 8'h00);
  cover property ($rose(csN) && sSh[19]);
endmodule : adcrr_monitor
`default_nettype wire

// [test/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic ref_clk, rstn, softReset, reqValid, reqWrite, reqReady, rspValid;
  logic convReq, convDone, esrLoad;
  logic [1:0] reqChan, convChan, esrChan, esrSel, lastCh;
  logic [6:0] reqCode, convCode;
  logic [9:0] convResult, esrResult;
  logic [31:0] rspData, pend, seed, r;
  logic [31:0] expQ [$];
  logic [6:0] mCode [4];
  logic [9:0] mRes [4];
  logic mFlag [4];
  int num_errors, checked, s;
  adcrr_if link ();
  adcrr_host adcrr_host_inst (.ref_clk(ref_clk), .rstn(rstn),
    .link(link.host), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqChan(reqChan), .reqCode(reqCode), .reqReady(reqReady),
    .rspValid(rspValid), .rspData(rspData));
  adcrr_device adcrr_device_inst (.ref_clk(ref_clk), .rstn(rstn),
    .link(link.dev), .softReset(softReset), .convReq(convReq),
    .convChan(convChan), .convCode(convCode), .convDone(convDone),
    .convResult(convResult), .esrLoad(esrLoad), .esrChan(esrChan),
    .esrSel(esrSel), .esrResult(esrResult));
  adcrr_monitor adcrr_monitor_inst (.ref_clk(ref_clk), .rstn(rstn),
    .sck(link.sck), .csN(link.csN), .mosi(link.mosi), .miso(link.miso),
    .misoOe(link.misoOe));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic usable(input logic [6:0] k);
    return (k >= 7'h01 && k <= 7'h13) || (k >= 7'h20 && k <= 7'h41) ||
      (k >= 7'h46 && k <= 7'h51);
  endfunction : usable
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic settle();
    while (reqReady !== 1'b1) @(posedge ref_clk);
    repeat (40) @(posedge ref_clk);
  endtask : settle
  // Reply to a read shows in the next frame
  task automatic frame(input logic w, input logic [1:0] c,
    input logic [6:0] k);
    settle();
    #1;
    reqValid = 1'b1;
    reqWrite = w;
    reqChan = c;
    reqCode = k;
    expQ.push_back(pend);
    pend = w ? 32'h0 : {4'h0, 8'h3A + {6'h00, c}, mFlag[c], 2'h0,
      mCode[c], mRes[c]};
    if (w) begin
      mCode[c] = k;
      lastCh = c;
    end else begin
      mFlag[c] = 1'b0;
    end
    @(posedge ref_clk);
    #1 reqValid = 1'b0;
  endtask : frame
  task automatic complete_run();
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run
  // Converter answers after a few cycles
  always @(posedge ref_clk) begin
    if (convReq === 1'b1 && rstn) begin
      chk({25'h0, convCode}, {25'h0, mCode[convChan]});
      chk({30'h0, convChan}, {30'h0, lastCh});
      #1 convResult = 10'(rnd() >> 22);
      repeat (3) @(posedge ref_clk);
      #1 convDone = 1'b1;
      mRes[convChan] = convResult;
      mFlag[convChan] = usable(mCode[convChan]);
      @(posedge ref_clk);
      #1 convDone = 1'b0;
    end
  end
  always @(posedge ref_clk) begin
    if (rspValid === 1'b1) begin
      chk(rspData, expQ.pop_front());
    end
  end
  initial begin
    repeat (90000) @(posedge ref_clk);
    num_errors++;
    complete_run();
  end
  initial begin
    {rstn, softReset, reqValid, reqWrite, reqChan, reqCode} = 0;
    {convDone, convResult, esrLoad, esrChan, esrSel, esrResult} = 0;
    pend = 32'h0;
    seed = 32'h0000678F;
    for (s = 0; s < 4; s++) {mCode[s], mRes[s], mFlag[s]} = 0;
    repeat (10) @(posedge ref_clk);
    #1 rstn = 1'b1;
    for (s = 0; s < 4; s++) begin
      frame(1'b1, s[1:0], 7'h0B + s[6:0]);
      frame(1'b0, s[1:0], 7'h7F);
      frame(1'b0, s[1:0], 7'h00);
    end
    frame(1'b1, 2'h2, 7'h15);
    for (s = 0; s < 4; s++) begin
      settle();
      #1 esrLoad = 1'b1;
      esrChan = s[1:0];
      esrSel = s[1:0];
      esrResult = 10'(rnd() >> 22);
      if (s < 3) {mCode[s], mRes[s], mFlag[s]} = {7'h14 + s[6:0],
        esrResult, 1'b1};
      @(posedge ref_clk);
      #1 esrLoad = 1'b0;
      frame(1'b0, s[1:0], 7'h00);
    end
    repeat (24) begin
      r = rnd();
      frame(r[0], r[2:1], r[9:3]);
    end
    frame(1'b1, 2'h3, 7'h2B);
    settle();
    #1 softReset = 1'b1;
    for (s = 0; s < 4; s++) {mCode[s], mRes[s], mFlag[s]} = 0;
    @(posedge ref_clk);
    #1 softReset = 1'b0;
    frame(1'b0, 2'h3, 7'h00);
    frame(1'b0, 2'h0, 7'h00);
    frame(1'b0, 2'h1, 7'h00);
    settle();
    complete_run();
  end
endmodule : testbench
`default_nettype wire
